// >>> shared/ragc_pkg.sv
// ==========================================================
// Register map and timing constants for the gain-timing block
// ==========================================================
package ragc_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index
    // ==========================================================
    localparam logic [7:0] RAGC_IDX_CTRL   = 8'h5E;  // Enable control
    localparam logic [7:0] RAGC_IDX_ATTACK = 8'h61;  // Attack time and scale
    localparam logic [7:0] RAGC_IDX_DECAY  = 8'h62;  // Decay time and scale
    localparam logic [7:0] RAGC_IDX_NOISE  = 8'h63;  // Noise debounce
    localparam logic [7:0] RAGC_IDX_STATUS = 8'h70;  // Timer status, read only

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RAGC_RST_CTRL   = 8'h00;
    localparam logic [7:0] RAGC_RST_ATTACK = 8'h00;
    localparam logic [7:0] RAGC_RST_DECAY  = 8'h00;
    localparam logic [7:0] RAGC_RST_NOISE  = 8'h00;

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int          RAGC_ENABLE_BIT  = 7;      // Gain control enable
    localparam int          RAGC_TIME_MSB    = 7;      // Time code field
    localparam int          RAGC_TIME_LSB    = 3;
    localparam int          RAGC_SCALE_MSB   = 2;      // Scale factor field
    localparam int          RAGC_SCALE_LSB   = 0;
    localparam int          RAGC_NOISE_MSB   = 4;      // Debounce code field
    localparam int          RAGC_NOISE_LSB   = 0;
    localparam logic [7:0]  RAGC_NOISE_WMASK = 8'h1F;  // Reserved bits never stored
    localparam logic [7:0]  RAGC_CTRL_WMASK  = 8'h80;

    // ==========================================================
    // Durations, in ADC word clock ticks
    // ==========================================================
    localparam int          RAGC_ATTACK_UNIT = 32;
    localparam int          RAGC_DECAY_UNIT  = 512;
    localparam int          RAGC_NOISE_UNIT  = 4096;
    localparam logic [4:0]  RAGC_NOISE_NONE  = 5'h01;  // No debounce delay
    localparam logic [4:0]  RAGC_NOISE_GEO   = 5'h04;  // First code with one extra doubling
    localparam logic [4:0]  RAGC_NOISE_LIN   = 5'h0C;  // First linear code
    localparam logic [4:0]  RAGC_NOISE_OFS   = 5'h0A;  // Linear multiplier offset
    localparam int          RAGC_DUR_W       = 22;     // Holds 63*512*128

    // ==========================================================
    // Timer slots
    // ==========================================================
    localparam int          RAGC_NUM_TMR     = 3;
    localparam int          RAGC_TMR_ATTACK  = 0;
    localparam int          RAGC_TMR_DECAY   = 1;
    localparam int          RAGC_TMR_NOISE   = 2;

endpackage

// >>> rtl/ragc_timer.sv
`timescale 1ns/1ps
// ==========================================================
// One-shot tick counter for one gain-loop duration
// ==========================================================
module ragc_timer
    import ragc_pkg::*;
#(
    parameter int DUR_W = RAGC_DUR_W
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             en_i,     // Gain control enabled
    input  wire logic             start_i,  // Start or restart
    input  wire logic             tick_i,   // ADC word clock tick
    input  wire logic [DUR_W-1:0] dur_i,    // Length in ticks
    output logic                  busy_o,   // Counting
    output logic                  done_o    // One-cycle end pulse
);

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic {RAGC_T_IDLE, RAGC_T_RUN} ragc_tstate_t;

    ragc_tstate_t     state;       // Current state
    ragc_tstate_t     next_state;
    logic [DUR_W-1:0] cnt;         // Ticks still to wait
    logic [DUR_W-1:0] next_cnt;
    logic             next_busy;
    logic             next_done;

    // Next state; a restart while running reloads the count
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_done  = 1'b0;
        if (!en_i)
        begin
            // Disabled gain control holds every timer idle
            next_state = RAGC_T_IDLE;
            next_cnt   = '0;
        end
        else if (start_i)
        begin
            if (dur_i == '0)
            begin
                // Zero length ends at once
                next_done  = 1'b1;
                next_state = RAGC_T_IDLE;
            end
            else
            begin
                next_state = RAGC_T_RUN;
                next_cnt   = dur_i;
            end
        end
        else
        begin
            unique case (state)
                RAGC_T_IDLE:
                begin
                    next_cnt = cnt;
                end
                RAGC_T_RUN:
                begin
                    if (tick_i)
                    begin
                        if (cnt == DUR_W'(1))
                        begin
                            next_done  = 1'b1;
                            next_state = RAGC_T_IDLE;
                        end
                        next_cnt = cnt - DUR_W'(1);
                    end
                end
            endcase
        end
        next_busy = (next_state == RAGC_T_RUN);
    end

    // Registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state  <= RAGC_T_IDLE;
            cnt    <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            cnt    <= next_cnt;
            busy_o <= next_busy;
            done_o <= next_done;
        end
    end

endmodule

// >>> rtl/ragc_timing_ctrl.sv
`timescale 1ns/1ps
module ragc_timing_ctrl
    import ragc_pkg::*;
#(
    parameter int ADR_W = 10,          // Byte address width
    parameter int DUR_W = RAGC_DUR_W   // Tick count width
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             adc_wclk_tick_i,
    input  wire logic             attack_start_i,
    input  wire logic             decay_start_i,
    input  wire logic             noise_start_i,
    output logic                  agc_enable_o,
    output logic      [DUR_W-1:0] attack_ticks_o,
    output logic      [DUR_W-1:0] decay_ticks_o,
    output logic      [DUR_W-1:0] noise_ticks_o,
    output logic                  attack_busy_o,
    output logic                  decay_busy_o,
    output logic                  noise_busy_o,
    output logic                  attack_done_o,
    output logic                  decay_done_o,
    output logic                  noise_done_o
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (ADR_W < 10)
    begin : g_adr_chk
        $error("ADR_W too small for the register map");
    end
    if (DUR_W < RAGC_DUR_W)
    begin : g_dur_chk
        $error("DUR_W too small for the longest duration");
    end

    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0]       ctrl_reg;        // Enable in bit 7
    logic [7:0]       attack_reg;      // Attack time and scale
    logic [7:0]       decay_reg;       // Decay time and scale
    logic [7:0]       noise_reg;       // Debounce code, top bits zero
    logic [7:0]       next_ctrl_reg;
    logic [7:0]       next_attack_reg;
    logic [7:0]       next_decay_reg;
    logic [7:0]       next_noise_reg;
    logic [31:0]      next_dat;
    logic             next_ack;
    logic [ADR_W-3:0] idx;             // Word index
    logic             wr_en;           // Write strobe, low lane
    logic [7:0]       status;          // Live timer state
    logic [RAGC_NUM_TMR-1:0] tmr_busy;
    logic [RAGC_NUM_TMR-1:0] tmr_done;
    logic [RAGC_NUM_TMR-1:0] tmr_start;

    assign idx   = wb_adr_i[ADR_W-1:2];
    // Writes land only on the ack edge, so a held request writes again every other cycle
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign status = {agc_enable_o, 4'h0, tmr_busy[RAGC_TMR_NOISE],
                     tmr_busy[RAGC_TMR_DECAY], tmr_busy[RAGC_TMR_ATTACK]};

    // Next register values and read data
    always_comb
    begin
        next_ctrl_reg   = ctrl_reg;
        next_attack_reg = attack_reg;
        next_decay_reg  = decay_reg;
        next_noise_reg  = noise_reg;
        next_ack        = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat        = 32'h0000_0000;
        if (wr_en)
        begin
            if (idx == (ADR_W-2)'(RAGC_IDX_CTRL))
            begin
                next_ctrl_reg = wb_dat_i[7:0] & RAGC_CTRL_WMASK;
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_ATTACK))
            begin
                next_attack_reg = wb_dat_i[7:0];
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_DECAY))
            begin
                next_decay_reg = wb_dat_i[7:0];
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_NOISE))
            begin
                next_noise_reg = wb_dat_i[7:0] & RAGC_NOISE_WMASK;
            end
        end
        if (next_ack && !wb_we_i)
        begin
            // Unmapped words read zero and are acked like the rest
            if (idx == (ADR_W-2)'(RAGC_IDX_CTRL))
            begin
                next_dat = {24'h00_0000, ctrl_reg};
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_ATTACK))
            begin
                next_dat = {24'h00_0000, attack_reg};
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_DECAY))
            begin
                next_dat = {24'h00_0000, decay_reg};
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_NOISE))
            begin
                next_dat = {24'h00_0000, noise_reg};
            end
            else if (idx == (ADR_W-2)'(RAGC_IDX_STATUS))
            begin
                next_dat = {24'h00_0000, status};
            end
        end
    end

    // Register and bus answer flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg   <= RAGC_RST_CTRL;
            attack_reg <= RAGC_RST_ATTACK;
            decay_reg  <= RAGC_RST_DECAY;
            noise_reg  <= RAGC_RST_NOISE;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
        end
        else
        begin
            ctrl_reg   <= next_ctrl_reg;
            attack_reg <= next_attack_reg;
            decay_reg  <= next_decay_reg;
            noise_reg  <= next_noise_reg;
            wb_ack_o   <= next_ack;
            wb_dat_o   <= next_dat;
        end
    end

    // ==========================================================
    // Duration decode
    // ==========================================================
    logic [DUR_W-1:0] next_attack_ticks;
    logic [DUR_W-1:0] next_decay_ticks;
    logic [DUR_W-1:0] next_noise_ticks;
    logic             next_enable;
    logic [4:0]       ncode;           // Debounce code

    assign ncode = noise_reg[RAGC_NOISE_MSB:RAGC_NOISE_LSB];

    // Arithmetic kept to shifts and three products by power-of-two units
    always_comb
    begin
        next_attack_ticks = (DUR_W'({attack_reg[RAGC_TIME_MSB:RAGC_TIME_LSB], 1'b1})
                            * DUR_W'(RAGC_ATTACK_UNIT)) << attack_reg[RAGC_SCALE_MSB:RAGC_SCALE_LSB];
        next_decay_ticks  = (DUR_W'({decay_reg[RAGC_TIME_MSB:RAGC_TIME_LSB], 1'b1})
                            * DUR_W'(RAGC_DECAY_UNIT)) << decay_reg[RAGC_SCALE_MSB:RAGC_SCALE_LSB];
        if (ncode <= RAGC_NOISE_NONE)
        begin
            // No delay; unlisted code 0 treated the same
            next_noise_ticks = '0;
        end
        else if (ncode < RAGC_NOISE_GEO)
        begin
            // Codes 2 and 3 give 4 and 8
            next_noise_ticks = DUR_W'(1) << ncode;
        end
        else if (ncode < RAGC_NOISE_LIN)
        begin
            // Doubling up to 2048 and 4096
            next_noise_ticks = DUR_W'(1) << (ncode + 5'h01);
        end
        else
        begin
            next_noise_ticks = DUR_W'(ncode - RAGC_NOISE_OFS) * DUR_W'(RAGC_NOISE_UNIT);
        end
        next_enable = ctrl_reg[RAGC_ENABLE_BIT];
    end

    // Duration outputs follow the registers one cycle later
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            attack_ticks_o <= '0;
            decay_ticks_o  <= '0;
            noise_ticks_o  <= '0;
            agc_enable_o   <= 1'b0;
        end
        else
        begin
            attack_ticks_o <= next_attack_ticks;
            decay_ticks_o  <= next_decay_ticks;
            noise_ticks_o  <= next_noise_ticks;
            agc_enable_o   <= next_enable;
        end
    end

    // ==========================================================
    // Duration timers
    // ==========================================================
    logic [DUR_W-1:0] tmr_dur [RAGC_NUM_TMR];

    assign tmr_start[RAGC_TMR_ATTACK] = attack_start_i;
    assign tmr_start[RAGC_TMR_DECAY]  = decay_start_i;
    assign tmr_start[RAGC_TMR_NOISE]  = noise_start_i;
    assign tmr_dur[RAGC_TMR_ATTACK]   = attack_ticks_o;
    assign tmr_dur[RAGC_TMR_DECAY]    = decay_ticks_o;
    assign tmr_dur[RAGC_TMR_NOISE]    = noise_ticks_o;
    assign attack_busy_o = tmr_busy[RAGC_TMR_ATTACK];
    assign decay_busy_o  = tmr_busy[RAGC_TMR_DECAY];
    assign noise_busy_o  = tmr_busy[RAGC_TMR_NOISE];
    assign attack_done_o = tmr_done[RAGC_TMR_ATTACK];
    assign decay_done_o  = tmr_done[RAGC_TMR_DECAY];
    assign noise_done_o  = tmr_done[RAGC_TMR_NOISE];

    // One timer per duration; enable gates them all
    for (genvar t = 0; t < RAGC_NUM_TMR; t++)
    begin : g_tmr
        ragc_timer #(.DUR_W(DUR_W)) u_tmr (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .en_i    (agc_enable_o),
            .start_i (tmr_start[t]),
            .tick_i  (adc_wclk_tick_i),
            .dur_i   (tmr_dur[t]),
            .busy_o  (tmr_busy[t]),
            .done_o  (tmr_done[t])
        );
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Reset-cycle guard: outputs hold zero at the first edge after release
    attack_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(attack_reg[2:0]) == 3'h0) |->
        int'(attack_ticks_o) == (2 * int'($past(attack_reg[7:3])) + 1) * 32)
        else $error("attack base duration wrong");
    attack_scale_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(attack_reg[7:3]) == 5'h00) |->
        int'(attack_ticks_o) == (32 << $past(attack_reg[2:0])))
        else $error("attack scale factor wrong");
    decay_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(decay_reg[2:0]) == 3'h0) |->
        int'(decay_ticks_o) == (2 * int'($past(decay_reg[7:3])) + 1) * 512)
        else $error("decay base duration wrong");
    decay_scale_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(decay_reg[7:3]) == 5'h00) |->
        int'(decay_ticks_o) == (512 << $past(decay_reg[2:0])))
        else $error("decay scale factor wrong");
    noise_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(ncode) == 5'h01) |-> noise_ticks_o == '0)
        else $error("debounce code 1 not zero");
    noise_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(ncode) == 5'h0A) |-> int'(noise_ticks_o) == 2048)
        else $error("debounce code 10 wrong");
    noise_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(ncode) == 5'h0B) |-> int'(noise_ticks_o) == 4096)
        else $error("debounce code 11 wrong");
    noise_lin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(ncode) >= 5'h0C) |-> int'(noise_ticks_o) == (int'($past(ncode)) - 10) * 4096)
        else $error("debounce linear code wrong");
    noise_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !$past(wb_we_i) && $past(idx) == (ADR_W-2)'(RAGC_IDX_NOISE)) |-> wb_dat_o[7:5] == 3'h0)
        else $error("reserved debounce bits not zero");
    timer_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !agc_enable_o |=> (tmr_busy == '0 && tmr_done == '0))
        else $error("timer active while disabled");
    attack_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(attack_reg) |=> int'(attack_ticks_o) ==
        ((2 * int'($past(attack_reg[7:3])) + 1) * 32) << $past(attack_reg[2:0]))
        else $error("effective attack time wrong");
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

endmodule

// >>> verif/test_ragc_timing_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the gain-timing register block
// ==========================================================
module test_ragc_timing_ctrl;
    import ragc_pkg::*;

    logic        clk_i       = 1'b0;    // 100 MHz clock
    logic        rst_i       = 1'b1;    // Synchronous reset
    logic        cyc         = 1'b0;    // Bus cycle
    logic        stb         = 1'b0;    // Bus strobe
    logic        we          = 1'b0;    // Write direction
    logic [9:0]  adr         = 10'h000; // Byte address
    logic [3:0]  sel         = 4'h0;    // Byte enables
    logic [31:0] wdat        = 32'h00000000;
    logic        tick        = 1'b0;    // Word clock tick
    logic        tick_slow   = 1'b0;    // Tick only every other cycle
    logic [2:0]  start       = 3'h0;    // Timer starts: noise, decay, attack
    wire  [31:0] rdat;                  // Read data
    wire         ack;                   // Bus answer
    wire  [2:0]  busy;                  // Timer busy flags
    wire  [2:0]  done;                  // Timer end pulses
    wire         en_o;                  // Enable copy
    wire  [21:0] t_att;                 // Effective attack ticks
    wire  [21:0] t_dec;                 // Effective decay ticks
    wire  [21:0] t_noi;                 // Noise debounce ticks
    logic [31:0] q;                     // Scratch read value
    int          error_cnt   = 0;
    int          checks_done = 0;

    // ==========================================================
    // Clock and device
    // ==========================================================
    always #5 clk_i = ~clk_i;

    // Word clock ticks: every cycle, or every other one when slowed
    always @(posedge clk_i)
        tick <= tick_slow ? ~tick : 1'b1;

    ragc_timing_ctrl dut
    (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .wb_cyc_i        (cyc),
        .wb_stb_i        (stb),
        .wb_we_i         (we),
        .wb_adr_i        (adr),
        .wb_sel_i        (sel),
        .wb_dat_i        (wdat),
        .wb_dat_o        (rdat),
        .wb_ack_o        (ack),
        .adc_wclk_tick_i (tick),
        .attack_start_i  (start[0]),
        .decay_start_i   (start[1]),
        .noise_start_i   (start[2]),
        .agc_enable_o    (en_o),
        .attack_ticks_o  (t_att),
        .decay_ticks_o   (t_dec),
        .noise_ticks_o   (t_noi),
        .attack_busy_o   (busy[0]),
        .decay_busy_o    (busy[1]),
        .noise_busy_o    (busy[2]),
        .attack_done_o   (done[0]),
        .decay_done_o    (done[1]),
        .noise_done_o    (done[2])
    );

    // ==========================================================
    // Shared helpers
    // ==========================================================
    // Four-state compare, counts every check
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; waits for ack with no latency assumed
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] r);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= s;
        adr  <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1, q);
        // Durations settle one edge after the ack edge
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 8'h00, 4'hF, q);
        chk(q, exp, what);
    endtask

    // Expected time: odd multiple of the unit, then scaled
    function automatic logic [31:0] dur_exp(input int unit, input int n, input int s);
        return (2 * n + 1) * unit * (1 << s);
    endfunction

    // Expected noise debounce ticks per code
    function automatic logic [31:0] noise_exp(input int c);
        if (c < 2)
            return 0;
        if (c < 4)
            return 4 << (c - 2);
        if (c < 12)
            return 1 << (c + 1);
        return (c - 10) * RAGC_NOISE_UNIT;
    endfunction

    // Pulse one start, count busy cycles up to the end pulse
    // Ticks seen while busy must equal the duration at any tick rate
    task automatic timer(input int k, input int dur, input bit run, input string what);
        int nb;
        int nt;
        bit seen;
        bit t0;
        nb   = 0;
        nt   = 0;
        seen = 1'b0;
        t0   = 1'b0;
        @(posedge clk_i);
        start[k] <= 1'b1;
        @(posedge clk_i);
        start[k] <= 1'b0;
        for (int i = 0; i < 2 * dur + 4; i++)
        begin
            @(posedge clk_i);
            if (i == 0)
                t0 = tick;
            if (!seen && busy[k] === 1'b1)
            begin
                nb++;
                if (tick === 1'b1)
                    nt++;
            end
            if (done[k] === 1'b1)
                seen = 1'b1;
        end
        chk(seen, run, {what, " end pulse"});
        // Slow ticks: span depends on the tick phase at the first edge
        chk(nb, run ? (tick_slow ? 2 * dur - t0 : dur) : 0, {what, " busy span"});
        chk(nt, run ? dur : 0, {what, " ticks counted"});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        rd(RAGC_IDX_ATTACK, 32'h00000000, "attack reset");
        rd(RAGC_IDX_DECAY, 32'h00000000, "decay reset");
        rd(RAGC_IDX_NOISE, 32'h00000000, "noise reset");
        chk(t_att, RAGC_ATTACK_UNIT, "attack default");
        chk(t_dec, RAGC_DECAY_UNIT, "decay default");
        chk(en_o, 1'b0, "enable reset");
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(RAGC_IDX_NOISE, 8'h1F);                          // all five code bits set, reserved bits written as zero
        rd(RAGC_IDX_NOISE, 32'h0000001F, "reserved bits");
        bus(1'b1, RAGC_IDX_ATTACK, 8'h5A, 4'h0, q);
        rd(RAGC_IDX_ATTACK, 32'h00000000, "sel0 ignored");
        wr(8'h10, 8'hA5);
        rd(8'h10, 32'h00000000, "unmapped read");
        wr(RAGC_IDX_CTRL, 8'hFF);
        rd(RAGC_IDX_CTRL, 32'h00000080, "ctrl bits");
        rd(RAGC_IDX_STATUS, 32'h00000080, "status enable");
        wr(RAGC_IDX_CTRL, 8'h00);
        $display("test registers done");
    endtask

    // Every code, every scale factor four times per field
    task automatic t_codes();
        for (int n = 0; n < 32; n++)
        begin
            wr(RAGC_IDX_ATTACK, 8'(n * 8 + n % 8));
            chk(t_att, dur_exp(RAGC_ATTACK_UNIT, n, n % 8), "attack ticks");
            wr(RAGC_IDX_DECAY, 8'(n * 8 + (7 - n % 8)));
            chk(t_dec, dur_exp(RAGC_DECAY_UNIT, n, 7 - n % 8), "decay ticks");
            wr(RAGC_IDX_NOISE, 8'(n));
            chk(t_noi, noise_exp(n), "noise ticks");
        end
        rd(RAGC_IDX_DECAY, 32'h000000F8, "decay readback");
        $display("test codes done");
    endtask

    task automatic t_timers();
        wr(RAGC_IDX_ATTACK, 8'h00);
        wr(RAGC_IDX_DECAY, 8'h00);
        wr(RAGC_IDX_NOISE, 8'h02);
        timer(0, 40, 1'b0, "start while disabled");
        wr(RAGC_IDX_CTRL, 8'h80);
        timer(0, RAGC_ATTACK_UNIT, 1'b1, "attack run");
        timer(1, RAGC_DECAY_UNIT, 1'b1, "decay run");
        timer(2, 4, 1'b1, "noise run");
        tick_slow <= 1'b1;
        timer(2, 4, 1'b1, "noise slow ticks");
        tick_slow <= 1'b0;
        wr(RAGC_IDX_NOISE, 8'h01);
        timer(2, 0, 1'b1, "noise no delay");
        $display("test timers done");
    endtask

    // Clearing enable mid-count must end the run silently
    task automatic t_abort();
        bit seen;
        seen = 1'b0;
        @(posedge clk_i);
        start[1] <= 1'b1;
        @(posedge clk_i);
        start[1] <= 1'b0;
        repeat (20) @(posedge clk_i);
        rd(RAGC_IDX_STATUS, 32'h00000082, "status decay busy");
        wr(RAGC_IDX_CTRL, 8'h00);
        repeat (RAGC_DECAY_UNIT + 8)
        begin
            @(posedge clk_i);
            if (done[1] === 1'b1)
                seen = 1'b1;
        end
        chk(seen, 1'b0, "abort end pulse");
        chk(busy[1], 1'b0, "abort busy");
        $display("test abort done");
    endtask

    // ==========================================================
    // Verdict, sequence and watchdog
    // ==========================================================
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_codes();
        t_timers();
        t_abort();
        conclude();
    end

    // Whole run needs a few thousand cycles; this is ample
    initial
    begin
        #600000;
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
